// *** ddc_adc_model.sv ***
// adc sample source and output word monitor facing the down-converter
`timescale 1ns/1ps

module ddc_adc_model
    import ddc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        run,
    input  wire logic        dual,
    input  wire logic [11:0] lvl,
    output ddc_sample_t      adc,
    input  wire ddc_word_t   ow,
    output int               words,
    output int               first_at,
    output int               max_pos,
    output logic [3:0][15:0] w
);
    logic run_d;
    int   cyc;
    int   pos;

    // ============================================================
    // source: one sample per clock, channels alternate in dual mode
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            adc   <= '0;
            run_d <= 1'b0;
        end else begin
            run_d     <= run;
            adc.valid <= run;
            adc.chan  <= (run && dual && run_d) ? {2'h0, ~adc.chan[0]} : 3'h0;
            // idle data toggles so a stale level never looks like a sample
            adc.data  <= run ? lvl : ~adc.data;
        end
    end

    // ============================================================
    // monitor: word count, first word time, position after strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin : mon
        int p;
        if (!arst_n) begin
            cyc      <= 0;
            words    <= 0;
            first_at <= -1;
            max_pos  <= 0;
            pos      <= 0;
            w        <= '0;
        end else if (run && !run_d) begin
            cyc      <= 0;
            words    <= 0;
            first_at <= -1;
            max_pos  <= 0;
        end else begin
            cyc <= cyc + 1;
            if (ow.valid) begin
                p = ow.strobe ? 0 : pos + 1;
                pos         <= p;
                words       <= words + 1;
                w[p[1:0]]   <= ow.data;
                if (first_at < 0) first_at <= cyc;
                if (p > max_pos) max_pos <= p;
            end
        end
    end
endmodule // ddc_adc_model

// *** ddc_defines.svh ***
// register indices, field positions and datapath constants of the down-converter
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// ============================================================
// register indices (byte address is four times the index)
`define DDC_IDX_CTRL      8'h80
`define DDC_IDX_FREQ0     8'h82
`define DDC_IDX_FREQ3     8'h85
`define DDC_IDX_PHASE0    8'h86
`define DDC_IDX_PHASE15   8'h95
`define DDC_IDX_MODE      8'h96
`define DDC_IDX_STATUS    8'h97
`define DDC_IDX_FOREIGN   8'h81
`define DDC_IDX_HI        2'h0

// ============================================================
// ddc_control fields
`define DDC_CTRL_FIRST_MIXER_STAGE     0
`define DDC_CTRL_REAL     1
`define DDC_CTRL_HBA      2
`define DDC_CTRL_HBB      3
`define DDC_CTRL_NCO      5
`define DDC_CTRL_AMPD     6
`define DDC_CTRL_PHSD     7

// ============================================================
// mode register fields
`define DDC_MODE_DUAL     0
`define DDC_MODE_DER_LO   1
`define DDC_MODE_DER_HI   3

// ============================================================
// datapath constants
`define DDC_HB_LATENCY    80
`define DDC_HB_PAD        (`DDC_HB_LATENCY - 5)
`define DDC_LFSR_SEED     16'hace1
`define DDC_LFSR_TAPS     16'hb400
`define DDC_PROD_LSB      11
`define DDC_HB_SHIFT      5
`define DDC_HB_CENTER_SH  4

`endif

// *** ddc_nco_mixer_halfband.sv ***
// down-converter: nco, first mixer, half-band decimator, second mixer, word serializer
// Functional notes
// - nco tunes from zero to fs in steps of fs over two to the 32.
// - frequency word is 32 bits over four byte registers, loaded by software.
// - each channel has its own phase offset; all share one frequency word.
// - separate control bits enable amplitude dither and phase dither.
// - mixer i/q may be decimated further, up to 128x.
// - real-output mode turns i/q into one real stream at twice the rate.
// - second mixer after decimation in single mode, before it in dual mode.
// - with extra decimation the up-conversion is fs over eight times that factor.
// - 16-bit unsigned phase offset per channel, value times 360 over 65536 degrees.
// - i is sample times cosine, q sample times sine of nco phase plus offset.
// - i and q interleave on one stream, i aligned to the word strobe.
// - dual i/q order is ch0 i, ch0 q, ch1 i, ch1 q.
// - half-band filter follows the first mixer and decimates by two.
// - one control bit per filter path picks high-pass or low-pass response.
// - half-band output is dc-centred i/q, forwarded to the second mixer if enabled.
// - half-band path adds 80 clock cycles of latency.
// - dual i/q without real mode runs as four streams, strobe on channel a i.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ddc_defines.svh"

module ddc_nco_mixer_halfband
    import ddc_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire ddc_apb_req_t apb_req,
    output ddc_apb_rsp_t      apb_rsp,
    input  wire ddc_sample_t  adc_in,
    output ddc_word_t         out_word
);

    // ============================================================
    // lookup and arithmetic helpers
    // quarter-wave table on the step grid, both ends included, so zero phase
    // gives an exact zero sine; spur level is set by the 64-step grid
    function automatic logic [15:0] qsin(input logic [4:0] k);
        case (k)
            5'h00:   qsin = 16'h0000;
            5'h01:   qsin = 16'h0c8c;
            5'h02:   qsin = 16'h18f9;
            5'h03:   qsin = 16'h2528;
            5'h04:   qsin = 16'h30fb;
            5'h05:   qsin = 16'h3c56;
            5'h06:   qsin = 16'h471c;
            5'h07:   qsin = 16'h5133;
            5'h08:   qsin = 16'h5a82;
            5'h09:   qsin = 16'h62f1;
            5'h0a:   qsin = 16'h6a6d;
            5'h0b:   qsin = 16'h70e2;
            5'h0c:   qsin = 16'h7641;
            5'h0d:   qsin = 16'h7a7c;
            5'h0e:   qsin = 16'h7d89;
            5'h0f:   qsin = 16'h7f61;
            default: qsin = 16'h7fff;
        endcase
    endfunction

    function automatic logic signed [15:0] sin64(input logic [5:0] p);
        logic [4:0]  k5;
        logic [15:0] m;
        k5 = p[4] ? (5'h10 - {1'h0, p[3:0]}) : {1'h0, p[3:0]};
        m = qsin(k5);
        sin64 = p[5] ? -$signed(m) : $signed(m);
    endfunction

    function automatic logic signed [15:0] hb_fir(input logic [6:0][15:0] t, input logic hp);
        logic signed [21:0] o;
        logic signed [21:0] m;
        logic signed [21:0] c;
        logic signed [21:0] y;
        o = 22'($signed(t[0])) + 22'($signed(t[6]));
        m = 22'($signed(t[2])) + 22'($signed(t[4]));
        m = (m <<< 3) + m;
        c = 22'($signed(t[3])) <<< `DDC_HB_CENTER_SH;
        y = hp ? (c + o - m) : (c - o + m);
        hb_fir = 16'(y >>> `DDC_HB_SHIFT);
    endfunction

    // rotation by a quarter of the i/q rate: pair k gives samples 2k, 2k+1
    function automatic ddc_item_t mix2(input ddc_item_t a, input logic rot);
        mix2       = a;
        mix2.i     = rot ? -a.i : a.i;
        mix2.q     = rot ? a.q : -a.q;
    endfunction

    // ============================================================
    // state
    ddc_state_t s;
    ddc_state_t next_s;

    logic [7:0]         idx;
    logic               mapped;
    logic [31:0]        rd;
    logic [15:0]        phase;
    logic signed [27:0] prod_i;
    logic signed [27:0] prod_q;
    logic signed [27:0] dith;
    ddc_item_t          dl;
    ddc_item_t          pre;
    ddc_item_t          post;
    logic [2:0]         extra_decimation_factor;
    logic [6:0]         der_last;
    logic               dual;
    logic               real_on;
    logic [2:0]         base;
    ddc_word_t          w0;
    ddc_word_t          w1;
    logic               pop;

    assign dual    = s.mode[`DDC_MODE_DUAL];
    assign real_on = s.ctrl[`DDC_CTRL_REAL];
    assign extra_decimation_factor     = s.mode[`DDC_MODE_DER_HI:`DDC_MODE_DER_LO];

    // ============================================================
    // register slave
    assign idx    = apb_req.paddr[9:2];
    assign mapped = (apb_req.paddr[11:10] == `DDC_IDX_HI) && (idx >= `DDC_IDX_CTRL)
                    && (idx <= `DDC_IDX_STATUS) && (idx != `DDC_IDX_FOREIGN);

    always_comb begin
        rd = '0;
        if (idx == `DDC_IDX_CTRL) begin
            rd[7:0] = s.ctrl;
        end else if (idx >= `DDC_IDX_FREQ0 && idx <= `DDC_IDX_FREQ3) begin
            rd[7:0] = s.freq[8*(idx-`DDC_IDX_FREQ0) +: 8];
        end else if (idx >= `DDC_IDX_PHASE0 && idx <= `DDC_IDX_PHASE15) begin
            rd[7:0] = s.poff[4'(idx-`DDC_IDX_PHASE0)];
        end else if (idx == `DDC_IDX_MODE) begin
            rd[7:0] = s.mode;
        end else if (idx == `DDC_IDX_STATUS) begin
            rd[7:0] = s.acc[31:24];
        end
    end

    assign apb_rsp.prdata  = s.rdata;
    assign apb_rsp.pready  = 1'h1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & s.rerr;
    assign out_word        = s.ow;

    // ============================================================
    // next state
    always_comb begin
        next_s = s;
        w0     = '0;
        w1     = '0;
        base   = '0;
        pop    = 1'h0;
        post   = '0;

        if (apb_req.psel && !apb_req.penable) begin
            next_s.rdata = rd;
            next_s.rerr  = !mapped;
        end
        if (apb_req.psel && apb_req.penable && apb_req.pwrite && mapped) begin
            if (idx == `DDC_IDX_CTRL) begin
                next_s.ctrl = apb_req.pwdata[7:0];
            end
            for (int k = 0; k < 4; k++) begin
                if (idx == `DDC_IDX_FREQ0 + 8'(k)) begin
                    next_s.freq[8*k +: 8] = apb_req.pwdata[7:0];
                end
            end
            for (int k = 0; k < 16; k++) begin
                if (idx == `DDC_IDX_PHASE0 + 8'(k)) begin
                    next_s.poff[k] = apb_req.pwdata[7:0];
                end
            end
            if (idx == `DDC_IDX_MODE) begin
                next_s.mode = apb_req.pwdata[7:0];
            end
        end

        // oscillator: accumulator is frozen while the nco is switched off
        if (s.ctrl[`DDC_CTRL_NCO]) begin
            next_s.acc = s.acc + s.freq;
        end
        next_s.lfsr = {1'h0, s.lfsr[15:1]} ^ (s.lfsr[0] ? `DDC_LFSR_TAPS : 16'h0000);

        // first mixer: offset of the sample's own channel, frequency shared
        phase = s.acc[31:16] + {s.poff[{adc_in.chan, 1'h1}], s.poff[{adc_in.chan, 1'h0}]};
        if (s.ctrl[`DDC_CTRL_PHSD]) begin
            phase = phase + {6'h00, s.lfsr[9:0]};
        end
        dith = s.ctrl[`DDC_CTRL_AMPD] ? 28'($unsigned(s.lfsr[10:0])) : '0;
        prod_i = adc_in.data * sin64(phase[15:10] + 6'h10) + dith;
        prod_q = adc_in.data * sin64(phase[15:10]) + dith;
        next_s.mix.valid = adc_in.valid & s.ctrl[`DDC_CTRL_FIRST_MIXER_STAGE];
        next_s.mix.chan  = adc_in.chan[0] & dual;
        next_s.mix.i     = prod_i[`DDC_PROD_LSB +: 16];
        next_s.mix.q     = prod_q[`DDC_PROD_LSB +: 16];

        // latency pad ahead of the filter
        next_s.dly = {s.dly[`DDC_HB_PAD-2:0], s.mix};
        dl         = s.dly[`DDC_HB_PAD-1];

        // half-band: per-channel taps, keep every second result
        next_s.hb = '0;
        if (dl.valid) begin
            next_s.tap_i[dl.chan]  = {s.tap_i[dl.chan][5:0], dl.i};
            next_s.tap_q[dl.chan]  = {s.tap_q[dl.chan][5:0], dl.q};
            next_s.dph[dl.chan]    = ~s.dph[dl.chan];
            next_s.hb.valid        = s.dph[dl.chan];
            next_s.hb.chan         = dl.chan;
            next_s.hb.i = hb_fir(next_s.tap_i[dl.chan],
                                 dl.chan ? s.ctrl[`DDC_CTRL_HBB] : s.ctrl[`DDC_CTRL_HBA]);
            next_s.hb.q = hb_fir(next_s.tap_q[dl.chan],
                                 dl.chan ? s.ctrl[`DDC_CTRL_HBB] : s.ctrl[`DDC_CTRL_HBA]);
        end

        // dual real mode: second mixer ahead of decimation
        pre = s.hb;
        if (s.hb.valid && dual && real_on) begin
            pre = mix2(s.hb, s.rot_pre[s.hb.chan]);
            next_s.rot_pre[s.hb.chan] = ~s.rot_pre[s.hb.chan];
        end

        // extra decimation by 2^der, integrate and dump
        der_last   = 7'((8'h01 << extra_decimation_factor) - 8'h01);
        next_s.dec = '0;
        if (pre.valid) begin
            if (extra_decimation_factor == 3'h0) begin
                next_s.dec = pre;
            end else begin
                next_s.sum_i[pre.chan] = s.sum_i[pre.chan] + 23'(pre.i);
                next_s.sum_q[pre.chan] = s.sum_q[pre.chan] + 23'(pre.q);
                next_s.dcnt[pre.chan]  = s.dcnt[pre.chan] + 7'h01;
                if (s.dcnt[pre.chan] == der_last) begin
                    next_s.dec.valid       = 1'h1;
                    next_s.dec.chan        = pre.chan;
                    next_s.dec.i           = 16'($signed(next_s.sum_i[pre.chan]) >>> extra_decimation_factor);
                    next_s.dec.q           = 16'($signed(next_s.sum_q[pre.chan]) >>> extra_decimation_factor);
                    next_s.sum_i[pre.chan] = '0;
                    next_s.sum_q[pre.chan] = '0;
                    next_s.dcnt[pre.chan]  = '0;
                end
            end
        end

        // single real mode: second mixer after decimation, so at fs/(8*2^der)
        post = s.dec;
        if (s.dec.valid && !dual && real_on) begin
            post = mix2(s.dec, s.rot_post[0]);
            next_s.rot_post[0] = ~s.rot_post[0];
        end

        // serializer: first word of a pair carries the strobe on channel 0
        w0.valid  = post.valid;
        w0.strobe = post.valid & (post.chan == 1'h0);
        w0.data   = post.i;
        w1.valid  = post.valid;
        w1.data   = post.q;
        pop       = (s.wcnt != 3'h0);
        next_s.ow = pop ? s.wq[0] : '0;
        for (int k = 0; k < 3; k++) begin
            next_s.wq[k] = pop ? s.wq[k+1] : s.wq[k];
        end
        next_s.wq[3] = pop ? '0 : s.wq[3];
        base = s.wcnt - {2'h0, pop};
        next_s.wcnt = base;
        if (post.valid && base <= 3'h2) begin
            next_s.wq[base[1:0]]        = w0;
            next_s.wq[2'(base + 3'h1)]  = w1;
            next_s.wcnt                 = base + 3'h2;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s      <= '0;
            s.lfsr <= `DDC_LFSR_SEED;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence apb_write_freq0;
        apb_req.psel && apb_req.penable && apb_req.pwrite && mapped
            && (idx == `DDC_IDX_FREQ0);
    endsequence

    sequence pair_words;
        (out_word.valid && out_word.strobe) ##1 (out_word.valid && !out_word.strobe);
    endsequence

    a_freq_write_lands: assert property (apb_write_freq0 |=>
        s.freq[7:0] == $past(apb_req.pwdata[7:0]))
        else $error("frequency byte not stored");

    a_acc_step: assert property (s.ctrl[`DDC_CTRL_NCO] |=>
        s.acc == $past(s.acc) + $past(s.freq))
        else $error("accumulator step wrong");

    a_acc_hold_off: assert property ((!s.ctrl[`DDC_CTRL_NCO])[*2] |->
        $stable(s.acc))
        else $error("accumulator moved while nco off");

    a_mix_gate: assert property (s.mix.valid |->
        $past(adc_in.valid) && $past(s.ctrl[`DDC_CTRL_FIRST_MIXER_STAGE]))
        else $error("mixer output without enabled sample");

    a_hb_pad_delay: assert property (s.dly[`DDC_HB_PAD-1] == $past(s.mix, `DDC_HB_PAD))
        else $error("half-band pad delay wrong");

    a_hb_decimate: assert property (s.hb.valid && !dual |=> !s.hb.valid)
        else $error("half-band did not decimate");

    a_word_pairs: assert property (out_word.strobe |-> pair_words)
        else $error("i word not followed by q word");

    a_dual_order: assert property ((dual && !real_on && out_word.strobe) |->
        pair_words ##1 out_word.valid && !out_word.strobe ##1 out_word.valid)
        else $error("dual i/q order broken");

    a_real_rotates: assert property ((s.dec.valid && !dual && real_on) |=>
        s.rot_post[0] != $past(s.rot_post[0]))
        else $error("second mixer rotation stuck");

    a_unmapped_err: assert property ((apb_req.psel && !apb_req.penable && !mapped) |=>
        s.rerr)
        else $error("unmapped access not flagged");

endmodule // ddc_nco_mixer_halfband

// *** ddc_nco_mixer_halfband_test.sv ***
// self-checking bench for the down-converter over apb and the sample stream
`timescale 1ns/1ps
`include "ddc_defines.svh"

module ddc_nco_mixer_halfband_test
    import ddc_pkg::*;
;
    logic             ref_clk;
    logic             arst_n;
    ddc_apb_req_t     req;
    ddc_apb_rsp_t     rsp;
    ddc_sample_t      adc;
    ddc_word_t        ow;
    logic             run;
    logic             dual;
    logic [11:0]      lvl;
    int               words;
    int               first_at;
    int               max_pos;
    logic [3:0][15:0] w;
    int               mismatches;
    int               checks_done;
    logic [31:0]      rd;
    logic [31:0]      r2;
    logic             err;
    logic [15:0]      i0;

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    ddc_nco_mixer_halfband u_ddc_nco_mixer_halfband (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .apb_req  (req),
        .apb_rsp  (rsp),
        .adc_in   (adc),
        .out_word (ow)
    );

    ddc_adc_model u_ddc_adc_model (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .run      (run),
        .dual     (dual),
        .lvl      (lvl),
        .adc      (adc),
        .ow       (ow),
        .words    (words),
        .first_at (first_at),
        .max_pos  (max_pos),
        .w        (w)
    );

    // ============================================================
    // checking and bus tasks
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rng(input string nm, input int v, input int lo, input int hi);
        chk(nm, 32'h1, {31'h0, v >= lo && v <= hi});
    endtask

    // call right after a rising edge; more keeps psel up for a back-to-back setup
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd,
                       input bit more);
        int n;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr_en;
        req.paddr   <= {2'h0, idx, 2'h0};
        req.pwdata  <= {24'h0, wd};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 100);
        if (n >= 100) mismatches++;
        rd  = rsp.prdata;
        err = rsp.pslverr;
        if (!more) begin
            req.psel    <= 1'b0;
            req.penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v, 1'b0);
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h0, 1'b0);
        chk(nm, exp, rd);
    endtask

    task automatic setfreq(input logic [31:0] v);
        for (int i = 0; i < 4; i++) wr(`DDC_IDX_FREQ0 + 8'(i), v[8*i+:8]);
    endtask

    task automatic setoff(input int ch, input logic [15:0] v);
        wr(`DDC_IDX_PHASE0 + 8'(2 * ch), v[7:0]);
        wr(`DDC_IDX_PHASE0 + 8'(2 * ch + 1), v[15:8]);
    endtask

    task automatic stream(input logic [7:0] ctl, input logic [7:0] md);
        wr(`DDC_IDX_MODE, md);
        wr(`DDC_IDX_CTRL, ctl);
        run  <= 1'b1;
        dual <= md[0];
        repeat (400) @(posedge ref_clk);
        run <= 1'b0;
        // drain the 80-cycle filter path before anything is judged
        repeat (120) @(posedge ref_clk);
    endtask

    // ============================================================
    // tests
    initial begin
        arst_n      = 1'b0;
        req         = '0;
        run         = 1'b0;
        dual        = 1'b0;
        lvl         = 12'h3e8;
        mismatches  = 0;
        checks_done = 0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rdc("ctrl reset", `DDC_IDX_CTRL, 32'h0);
        for (int i = 0; i < 20; i++) wr(`DDC_IDX_FREQ0 + 8'(i), 8'h5a ^ 8'(i));
        for (int i = 0; i < 20; i++) rdc("byte reg", `DDC_IDX_FREQ0 + 8'(i), {24'h0, 8'h5a ^ 8'(i)});
        wr(`DDC_IDX_CTRL, 8'hec);
        rdc("ctrl", `DDC_IDX_CTRL, 32'hec);
        apb(1'b1, `DDC_IDX_FOREIGN, 8'hff, 1'b0);
        chk("unmapped err", 32'h1, {31'h0, err});
        rdc("unmapped data", `DDC_IDX_FOREIGN, 32'h0);
        apb(1'b1, `DDC_IDX_STATUS, 8'hff, 1'b0);
        chk("status write err", 32'h0, {31'h0, err});
        for (int k = 0; k < 3; k++) begin
            setfreq(k == 0 ? 32'h01000000 : k == 1 ? 32'h00800000 : 32'hff000000);
            wr(`DDC_IDX_CTRL, 8'h20);
            apb(1'b0, `DDC_IDX_STATUS, 8'h0, 1'b1);
            r2 = rd;
            apb(1'b0, `DDC_IDX_STATUS, 8'h0, 1'b0);
            chk("acc step", k == 0 ? 32'h2 : k == 1 ? 32'h1 : 32'hfe, {24'h0, 8'(rd[7:0] - r2[7:0])});
        end
        // mid-run reset clears the accumulator; held past the filter pad depth
        arst_n <= 1'b0;
        repeat (80) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rdc("ctrl after reset", `DDC_IDX_CTRL, 32'h0);
        setfreq(32'h0);
        setoff(0, 16'h0);
        setoff(1, 16'h4000);
        stream(8'h21, 8'h0);
        rng("latency", first_at, 80, 90);
        rng("words", words, 396, 404);
        chk("q at zero phase", 32'h0, {16'h0, w[1]});
        chk("strobe period", 32'h1, max_pos);
        i0 = w[0];
        chk("i level", 32'h1, {31'h0, i0 !== 16'h0 && i0[15] === 1'b0});
        setoff(0, 16'h4000);
        stream(8'h21, 8'h0);
        chk("i at 90", 32'h0, {16'h0, w[0]});
        chk("q at 90", {16'h0, i0}, {16'h0, w[1]});
        setoff(0, 16'h0);
        stream(8'h25, 8'h0);
        chk("hp differs", 32'h1, {31'h0, w[0] !== i0});
        stream(8'h21, 8'h1);
        chk("ch0 i", {16'h0, i0}, {16'h0, w[0]});
        chk("ch0 q", 32'h0, {16'h0, w[1]});
        chk("ch1 i", 32'h0, {16'h0, w[2]});
        chk("ch1 q", {16'h0, i0}, {16'h0, w[3]});
        chk("dual period", 32'h3, max_pos);
        for (int k = 1; k < 4; k++) begin
            stream(8'h21, 8'(k << 1));
            rng("dec words", words, (400 >> k) - 4, (400 >> k) + 4);
            chk("dec level", {16'h0, i0}, {16'h0, w[0]});
        end
        stream(8'h23, 8'h0);
        rng("real words", words, 396, 404);
        chk("real period", 32'h1, max_pos);
        stream(8'h23, 8'h1);
        rng("dual real words", words, 396, 404);
        chk("dual real period", 32'h3, max_pos);
        stream(8'he1, 8'h0);
        rng("dither i", int'(w[0]), int'(i0), int'(i0) + 2);
        wr(`DDC_IDX_CTRL, 8'h00);
        tally_and_finish();
    end

    // whole run is near 5600 cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule // ddc_nco_mixer_halfband_test

// *** ddc_pkg.sv ***
// types shared by the down-converter datapath and its register slave
package ddc_pkg;
`include "ddc_defines.svh"

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ddc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ddc_apb_rsp_t;

    typedef struct packed {
        logic               valid;
        logic [2:0]         chan;
        logic signed [11:0] data;
    } ddc_sample_t;

    typedef struct packed {
        logic               valid;
        logic               chan;
        logic signed [15:0] i;
        logic signed [15:0] q;
    } ddc_item_t;

    typedef struct packed {
        logic        valid;
        logic        strobe;
        logic [15:0] data;
    } ddc_word_t;

    typedef struct packed {
        logic [7:0]                   ctrl;
        logic [31:0]                  freq;
        logic [15:0][7:0]             poff;
        logic [7:0]                   mode;
        logic [31:0]                  acc;
        logic [15:0]                  lfsr;
        ddc_item_t                    mix;
        ddc_item_t [`DDC_HB_PAD-1:0]  dly;
        logic [1:0][6:0][15:0]        tap_i;
        logic [1:0][6:0][15:0]        tap_q;
        logic [1:0]                   dph;
        ddc_item_t                    hb;
        logic [1:0]                   rot_pre;
        logic [1:0]                   rot_post;
        logic [1:0][6:0]              dcnt;
        logic [1:0][22:0]             sum_i;
        logic [1:0][22:0]             sum_q;
        ddc_item_t                    dec;
        ddc_word_t [3:0]              wq;
        logic [2:0]                   wcnt;
        ddc_word_t                    ow;
        logic [31:0]                  rdata;
        logic                         rerr;
    } ddc_state_t;

endpackage
